// ==== design/aur_rx.sv ====
// Purpose: Asynchronous serial receiver with start qualification,
//          majority bit recovery and a two-entry receive buffer.
// Assumes: sample_tick_i is a one-cycle enable at 16x the bit rate, or 8x
//          when double speed is selected, from a baud divider on core_clk_i.
// Notes:   Registers sit on a plain port with read data one cycle later.
//          Nothing here measures baud error; the sender and the divider must
//          keep the rate close enough for the centre vote to land in each bit.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

`include "aur_rx_defs.svh"

module aur_rx
    import aur_rx_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset.
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // Serial line and oversampling enable.
    input  wire logic       serial_in_line_i,
    input  wire logic       sample_tick_i,
    // Register port.
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_we_i,
    input  wire logic       reg_re_i,
    output logic      [7:0] reg_rdata_o,
    // Status levels.
    output logic            rx_unread_flag_o,
    output logic            stop_bit_error_flag_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State and buffer.

    localparam int ENTRY_W = $bits(aur_entry_t);

    aur_rx_state_t s_q;
    aur_rx_state_t s_d;

    logic               push_valid;
    logic               push_ready;
    aur_entry_t         push_entry;
    logic               pop;
    logic               head_valid;
    logic [ENTRY_W-1:0] head_raw;
    aur_entry_t         head;

    assign head = aur_entry_t'(head_raw);

    // Frames and their stop error share one entry, so the status flags always
    // describe the frame that the next data read returns.
    aur_rx_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .flush_i      (!s_q.on),
        .push_valid_i (push_valid),
        .push_ready_o (push_ready),
        .push_data_i  (push_entry),
        .pop_i        (pop),
        .pop_valid_o  (head_valid),
        .pop_data_o   (head_raw)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb
    begin
        logic       line;
        logic [4:0] spb;
        logic [4:0] vfirst;
        logic [4:0] vlast;
        logic [4:0] cnt_new;
        logic [3:0] nd;
        logic       maj;
        logic       in_win;

        // Only the second stage is ever looked at.
        line    = s_q.sync2;
        spb     = s_q.ds ? `AUR_SPB_DOUBLE : `AUR_SPB_NORMAL;
        vfirst  = s_q.ds ? `AUR_VOTE_DOUBLE : `AUR_VOTE_NORMAL;
        vlast   = vfirst + `AUR_VOTE_SPAN;
        // A speed change mid-frame can leave the counter above the new bit
        // length; wrapping on greater-or-equal stops it running on to 31.
        cnt_new = (s_q.cnt >= spb) ? 5'h01 : s_q.cnt + 5'h01;
        in_win  = (cnt_new >= vfirst) && (cnt_new <= vlast);
        nd      = s_q.char_size + {3'h0, s_q.par_en};
        maj     = (s_q.votes[1] & s_q.votes[0]) |
                  (s_q.votes[1] & line) |
                  (s_q.votes[0] & line);

        s_d        = s_q;
        push_valid = 1'b0;
        pop        = 1'b0;
        push_entry = '0;
        s_d.sync1  = serial_in_line_i;
        s_d.sync2  = s_q.sync1;

        // Data bits land by position, so unused upper bits read as zero.
        for (int i = 0; i < 9; i++)
        begin
            push_entry.data[i] = s_q.shreg[i] & (4'(i) < s_q.char_size);
        end
        push_entry.par_bit  = s_q.par_en & s_q.shreg[s_q.char_size];
        push_entry.stop_err = !maj;

        // Everything below moves only on a tick, so the divider alone sets the
        // bit rate and no derived clock is needed.
        if (sample_tick_i)
        begin
            s_d.prev_line = line;
            case (s_q.state)
                AUR_IDLE:
                begin
                    // Idle samples leave the counter at its last value.
                    if (s_q.prev_line && !line)
                    begin
                        s_d.state   = AUR_FRAME;
                        s_d.cnt     = 5'h01;
                        s_d.bit_idx = 4'h0;
                        s_d.shreg   = '0;
                    end
                end
                AUR_FRAME:
                begin
                    s_d.cnt = cnt_new;
                    if (s_q.cnt >= spb)
                    begin
                        s_d.bit_idx = s_q.bit_idx + 4'h1;
                    end
                    // Two window samples wait here; the third is the live one,
                    // so the vote completes on the last window tick.
                    if (in_win)
                    begin
                        s_d.votes = {s_q.votes[0], line};
                    end
                    if (cnt_new == vlast)
                    begin
                        if (s_q.bit_idx == 4'h0)
                        begin
                            if (maj)
                            begin
                                s_d.state = AUR_IDLE;
                            end
                        end
                        else if (s_q.bit_idx <= nd)
                        begin
                            s_d.shreg[s_q.bit_idx - 4'h1] = maj;
                        end
                        else
                        begin
                            // First stop bit ends the frame; later ones look idle.
                            push_valid = 1'b1;
                            s_d.state  = s_q.ds ? AUR_TAIL : AUR_IDLE;
                        end
                    end
                end
                AUR_TAIL:
                begin
                    // Double speed waits one more sample before edge search.
                    s_d.state = AUR_IDLE;
                end
                default:
                begin
                    s_d.state = AUR_IDLE;
                end
            endcase
        end

        // Turning the receiver off abandons any frame in flight.
        if (!s_q.on)
        begin
            s_d.state = AUR_IDLE;
        end

        ////////////////////////////////////////////////////////////////////////
        // Register writes.

        // Clearing the on bit also flushes the buffer on the next edge,
        // because the flush input follows the registered on bit.
        if (reg_we_i)
        begin
            if (reg_addr_i == `AUR_OFS_STATUS)
            begin
                s_d.ds = reg_wdata_i[`AUR_STA_DS_BIT];
            end
            else if (reg_addr_i == `AUR_OFS_CTRL)
            begin
                s_d.on     = reg_wdata_i[`AUR_CTL_ON_BIT];
                s_d.par_en = reg_wdata_i[`AUR_CTL_PAR_BIT];
                // Sizes outside the supported range keep the old size.
                if ((reg_wdata_i[`AUR_CTL_SIZE_MSB:`AUR_CTL_SIZE_LSB] >= `AUR_CHAR_SIZE_MIN) &&
                    (reg_wdata_i[`AUR_CTL_SIZE_MSB:`AUR_CTL_SIZE_LSB] <= `AUR_CHAR_SIZE_MAX))
                begin
                    s_d.char_size = reg_wdata_i[`AUR_CTL_SIZE_MSB:`AUR_CTL_SIZE_LSB];
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Register reads: data stand for one cycle only.
        // Software must read DATA_HI and STATUS before DATA, since the data
        // read pops the head entry and its flags with it.

        s_d.rdata = 8'h00;
        if (reg_re_i)
        begin
            if (reg_addr_i == `AUR_OFS_DATA)
            begin
                if (head_valid)
                begin
                    s_d.rdata = head.data[7:0];
                    pop       = 1'b1;
                end
                s_d.lost = 1'b0;
            end
            else if (reg_addr_i == `AUR_OFS_STATUS)
            begin
                s_d.rdata[`AUR_STA_UNREAD_BIT]  = head_valid;
                s_d.rdata[`AUR_STA_STOPERR_BIT] = head_valid & head.stop_err;
                s_d.rdata[`AUR_STA_LOST_BIT]    = s_q.lost;
                s_d.rdata[`AUR_STA_DS_BIT]      = s_q.ds;
            end
            else if (reg_addr_i == `AUR_OFS_CTRL)
            begin
                s_d.rdata[`AUR_CTL_ON_BIT]  = s_q.on;
                s_d.rdata[`AUR_CTL_PAR_BIT] = s_q.par_en;
                s_d.rdata[`AUR_CTL_SIZE_MSB:`AUR_CTL_SIZE_LSB] = s_q.char_size;
            end
            else
            begin
                s_d.rdata[`AUR_DHI_BIT8_BIT] = head_valid & head.data[8];
                s_d.rdata[`AUR_DHI_PAR_BIT]  = head_valid & head.par_bit;
            end
        end

        // A frame dropped on a full buffer wins over the clear by a data read.
        if (push_valid && !push_ready)
        begin
            s_d.lost = 1'b1;
        end
        if (!s_q.on)
        begin
            s_d.lost = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            // The line stages start high so that leaving reset never looks
            // like a falling edge on an idle line.
            s_q           <= '0;
            s_q.sync1     <= 1'b1;
            s_q.sync2     <= 1'b1;
            s_q.prev_line <= 1'b1;
            s_q.state     <= AUR_IDLE;
            s_q.char_size <= `AUR_RST_CHAR_SIZE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata_o           = s_q.rdata;
    assign rx_unread_flag_o      = head_valid;
    assign stop_bit_error_flag_o = head_valid & head.stop_err;

endmodule : aur_rx

`default_nettype wire

// ==== design/aur_rx_defs.svh ====
// Purpose: Constants for the asynchronous receive front end.
// Assumes: Included by its bare name after the package.
// Notes:   Offsets are word indices on the plain register port.
`ifndef AUR_RX_DEFS_SVH
`define AUR_RX_DEFS_SVH

// Register offsets.
`define AUR_OFS_DATA      2'h0
`define AUR_OFS_STATUS    2'h1
`define AUR_OFS_CTRL      2'h2
`define AUR_OFS_DATA_HI   2'h3

// Status register fields.
`define AUR_STA_UNREAD_BIT  7
`define AUR_STA_STOPERR_BIT 4
`define AUR_STA_LOST_BIT    3
`define AUR_STA_DS_BIT      1

// Control register fields.
`define AUR_CTL_ON_BIT      0
`define AUR_CTL_PAR_BIT     1
`define AUR_CTL_SIZE_LSB    4
`define AUR_CTL_SIZE_MSB    7

// Extra data register fields.
`define AUR_DHI_BIT8_BIT    0
`define AUR_DHI_PAR_BIT     1

// Reset value and accepted character size range.
`define AUR_RST_CHAR_SIZE   4'h8
`define AUR_CHAR_SIZE_MIN   4'h5
`define AUR_CHAR_SIZE_MAX   4'h9

// Sampling figures: samples per bit and first voting sample.
`define AUR_SPB_NORMAL      5'h10
`define AUR_SPB_DOUBLE      5'h08
`define AUR_VOTE_NORMAL     5'h08
`define AUR_VOTE_DOUBLE     5'h04
`define AUR_VOTE_SPAN       5'h02

`endif

// ==== design/aur_rx_pkg.sv ====
// Purpose: Types for the asynchronous receive front end.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in aur_rx_defs.svh.
package aur_rx_pkg;

    typedef enum logic [1:0] {
        AUR_IDLE,
        AUR_FRAME,
        AUR_TAIL
    } aur_state_t;

    // One buffered frame: stop error travels with its data.
    typedef struct packed {
        logic       stop_err;
        logic       par_bit;
        logic [8:0] data;
    } aur_entry_t;

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev_line;
        aur_state_t state;
        logic [4:0] cnt;
        logic [3:0] bit_idx;
        logic [1:0] votes;
        logic [9:0] shreg;
        logic       on;
        logic       ds;
        logic       par_en;
        logic [3:0] char_size;
        logic       lost;
        logic [7:0] rdata;
    } aur_rx_state_t;

endpackage : aur_rx_pkg

// ==== design/aur_rx_fifo.sv ====
// Purpose: Small receive buffer with flush.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Flush empties every entry in one cycle.
`timescale 1ns/1ps
`default_nettype none

module aur_rx_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // Control.
    input  wire logic             flush_i,
    // Fill side.
    input  wire logic             push_valid_i,
    output logic                  push_ready_o,
    input  wire logic [WIDTH-1:0] push_data_i,
    // Drain side.
    input  wire logic             pop_i,
    output logic                  pop_valid_o,
    output logic [WIDTH-1:0]      pop_data_o
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CFULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               rd;
        logic [PW-1:0]               wr;
        logic [CW-1:0]               count;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        do_push;
    logic        do_pop;

    assign push_ready_o = (s_q.count != CFULL);
    assign pop_valid_o  = (s_q.count != '0);
    assign pop_data_o   = s_q.mem[s_q.rd];
    assign do_push      = push_valid_i && push_ready_o;
    assign do_pop       = pop_i && pop_valid_o;

    always_comb
    begin
        s_d = s_q;
        if (do_push)
        begin
            s_d.mem[s_q.wr] = push_data_i;
            s_d.wr = (s_q.wr == PLAST) ? '0 : s_q.wr + PW'(1);
        end
        if (do_pop)
        begin
            s_d.rd = (s_q.rd == PLAST) ? '0 : s_q.rd + PW'(1);
        end
        if (do_push && !do_pop)
        begin
            s_d.count = s_q.count + CW'(1);
        end
        else if (do_pop && !do_push)
        begin
            s_d.count = s_q.count - CW'(1);
        end
        // Unread entries are discarded, not drained.
        if (flush_i)
        begin
            s_d.rd    = '0;
            s_d.wr    = '0;
            s_d.count = '0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule : aur_rx_fifo

`default_nettype wire

// ==== tb/aur_rx_sva.sv ====
// Purpose: Port-level assertions for the asynchronous receiver.
// Assumes: Bound to every aur_rx instance; one clock domain.
// Notes:   The flush lands one edge after the off write, so the flag is low two edges on.
`timescale 1ns/1ps
`default_nettype none

`include "aur_rx_defs.svh"

module aur_rx_sva (
    // Clock and reset.
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    // Register port.
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_we_i,
    input wire logic       reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    // Oversampling and status.
    input wire logic       sample_tick_i,
    input wire logic       rx_unread_flag_o,
    input wire logic       stop_bit_error_flag_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    logic pop_c;
    logic off_c;
    logic sta_c;
    assign pop_c = reg_re_i && (reg_addr_i == `AUR_OFS_DATA);
    assign sta_c = reg_re_i && (reg_addr_i == `AUR_OFS_STATUS);
    assign off_c = reg_we_i && (reg_addr_i == `AUR_OFS_CTRL) && !reg_wdata_i[0];

    ////////////////////////////////////////////////////////////////
    chk_flush_off: assert property (off_c |-> ##2 !rx_unread_flag_o)
        else $error("buffer not flushed after receiver off");
    chk_sta_unread: assert property (sta_c |=> reg_rdata_o[7] == $past(rx_unread_flag_o))
        else $error("status unread bit differs from flag");
    chk_sta_err: assert property (sta_c |=> reg_rdata_o[4] == $past(stop_bit_error_flag_o))
        else $error("status stop error bit differs from flag");
    chk_err_empty: assert property (!rx_unread_flag_o |-> !stop_bit_error_flag_o)
        else $error("stop error shown with empty buffer");
    chk_push_tick: assert property ($rose(rx_unread_flag_o) |-> $past(sample_tick_i))
        else $error("frame stored without a sample tick");
    chk_fall_cause: assert property ($fell(rx_unread_flag_o)
        |-> $past(pop_c) || $past(off_c) || $past(off_c, 2))
        else $error("unread flag fell without read or flush");
    chk_flag_hold: assert property (rx_unread_flag_o && !pop_c && !off_c && !$past(off_c)
        |=> rx_unread_flag_o)
        else $error("unread flag dropped while frames wait");
    chk_empty_read: assert property (pop_c && !rx_unread_flag_o |=> reg_rdata_o == 8'h00)
        else $error("data read from empty buffer not zero");

    cover property (pop_c && rx_unread_flag_o);
    cover property (off_c && rx_unread_flag_o);
    cover property ($rose(stop_bit_error_flag_o));
endmodule : aur_rx_sva

bind aur_rx aur_rx_sva u_sva (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .sample_tick_i(sample_tick_i),
    .rx_unread_flag_o(rx_unread_flag_o), .stop_bit_error_flag_o(stop_bit_error_flag_o)
);

`default_nettype wire

// ==== tb/aur_tx_model.sv ====
// Purpose: Remote asynchronous transmitter driving the receive line.
// Assumes: Line changes only just after a sample tick edge.
// Notes:   Bit lengths are whole ticks, so the rate error is zero.
`timescale 1ns/1ps
`default_nettype none

module aur_tx_model (
    // Clock and oversampling enable.
    input  wire logic core_clk_i,
    input  wire logic sample_tick_i,
    // Serial line, idle high.
    output var logic  line_o
);
    initial line_o = 1'b1;

    // Holds level v on the line for n tick intervals.
    task automatic hold(input logic v, input int n);
        for (int i = 0; i < n; i++)
        begin
            do @(posedge core_clk_i); while (sample_tick_i !== 1'b1);
            if (i == 0) line_o <= v;
        end
    endtask : hold

    // With nz set, sample 8 (4) of the start and data bits is inverted.
    task automatic send(input logic [9:0] bits, input int n, input int spb,
                        input logic stop_v, input int stop_t, input logic nz);
        for (int i = 0; i <= n; i++)
        begin
            logic v;
            v = (i == 0) ? 1'b0 : bits[i-1];
            hold(v, spb / 2 - 1);
            hold(v ^ nz, 1);
            hold(v, spb / 2);
        end
        hold(stop_v, stop_t);
        if (stop_v == 1'b0) hold(1'b1, spb);
    endtask : send
endmodule : aur_tx_model

`default_nettype wire

// ==== tb/tb_aur_rx.sv ====
// Purpose: Self-checking bench for the asynchronous receiver.
// Assumes: Sample tick every fourth clock.
// Notes:   Frames come from the transmitter model.
`timescale 1ns/1ps
`default_nettype none

`include "aur_rx_defs.svh"

module tb_aur_rx;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       tick = 1'b0;
    logic [1:0] tcnt = 2'h0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       we = 1'b0;
    logic       re = 1'b0;
    logic [7:0] rdata;
    logic       unread;
    logic       stoperr;
    logic       line;
    logic [7:0] rd_v;
    int         failures = 0;
    int         samples_checked = 0;

    initial forever #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end

    aur_rx DUT (
        .core_clk_i(clk), .rst_i(rst), .serial_in_line_i(line), .sample_tick_i(tick),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .rx_unread_flag_o(unread), .stop_bit_error_flag_o(stoperr)
    );
    aur_tx_model u_tx (.core_clk_i(clk), .sample_tick_i(tick), .line_o(line));

    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re   <= 1'b0;
        #1 rd_v = rdata;
    endtask : rd

    task automatic wait_flag();
        for (int i = 0; i < 3000 && unread !== 1'b1; i++) @(posedge clk);
    endtask : wait_flag

    task automatic t_reset();
        rd(`AUR_OFS_STATUS);  check("status", rd_v, 8'h00);
        rd(`AUR_OFS_CTRL);    check("ctrl", rd_v, 8'h80);
        rd(`AUR_OFS_DATA_HI); check("data_hi", rd_v, 8'h00);
        rd(`AUR_OFS_DATA);    check("empty data", rd_v, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_normal();
        wr(`AUR_OFS_CTRL, 8'h81);
        u_tx.send(10'h0A5, 8, 16, 1'b1, 16, 1'b1);
        wait_flag();
        rd(`AUR_OFS_STATUS); check("status", rd_v, 8'h80);
        rd(`AUR_OFS_DATA);   check("data", rd_v, 8'hA5);
        check("unread", {7'h0, unread}, 8'h00);
        $display("test normal done");
    endtask : t_normal

    task automatic t_noise();
        u_tx.hold(1'b0, 8);
        u_tx.hold(1'b1, 200);
        check("unread after noise", {7'h0, unread}, 8'h00);
        wr(`AUR_OFS_STATUS, 8'h02);
        u_tx.hold(1'b0, 4);
        u_tx.hold(1'b1, 100);
        check("unread after ds noise", {7'h0, unread}, 8'h00);
        wr(`AUR_OFS_STATUS, 8'h00);
        u_tx.send(10'h05A, 8, 16, 1'b1, 16, 1'b0);
        wait_flag();
        rd(`AUR_OFS_DATA); check("data after noise", rd_v, 8'h5A);
        $display("test noise done");
    endtask : t_noise

    task automatic t_back();
        u_tx.send(10'h011, 8, 16, 1'b1, 10, 1'b0);
        u_tx.send(10'h0EE, 8, 16, 1'b0, 16, 1'b0);
        wait_flag();
        rd(`AUR_OFS_STATUS); check("status first", rd_v, 8'h80);
        rd(`AUR_OFS_DATA);   check("data first", rd_v, 8'h11);
        rd(`AUR_OFS_STATUS); check("status second", rd_v, 8'h90);
        check("stop flag", {7'h0, stoperr}, 8'h01);
        rd(`AUR_OFS_DATA);   check("data second", rd_v, 8'hEE);
        rd(`AUR_OFS_STATUS); check("drained", rd_v, 8'h00);
        $display("test back done");
    endtask : t_back

    task automatic t_flush();
        u_tx.send(10'h033, 8, 16, 1'b1, 16, 1'b0);
        u_tx.send(10'h044, 8, 16, 1'b0, 16, 1'b0);
        // A third frame meets a full buffer and is dropped.
        u_tx.send(10'h055, 8, 16, 1'b1, 16, 1'b0);
        wait_flag();
        rd(`AUR_OFS_STATUS); check("status lost", rd_v, 8'h88);
        wr(`AUR_OFS_CTRL, 8'h80);
        rd(`AUR_OFS_STATUS); check("status off", rd_v, 8'h00);
        rd(`AUR_OFS_DATA);   check("data off", rd_v, 8'h00);
        $display("test flush done");
    endtask : t_flush

    task automatic t_formats();
        logic [7:0] ctl[3]  = '{8'h51, 8'h93, 8'h73};
        logic [7:0] sta[3]  = '{8'h00, 8'h02, 8'h02};
        int         spb[3]  = '{16, 8, 8};
        int         nb[3]   = '{5, 10, 8};
        logic [9:0] bits[3] = '{10'h016, 10'h3A5, 10'h055};
        logic [7:0] dlo[3]  = '{8'h16, 8'hA5, 8'h55};
        logic [7:0] dhi[3]  = '{8'h00, 8'h03, 8'h00};
        for (int k = 0; k < 3; k++)
        begin
            wr(`AUR_OFS_CTRL, ctl[k]);
            wr(`AUR_OFS_STATUS, sta[k]);
            rd(`AUR_OFS_STATUS); check("speed", rd_v, sta[k]);
            u_tx.send(bits[k], nb[k], spb[k], 1'b1, spb[k], k[0]);
            wait_flag();
            rd(`AUR_OFS_DATA_HI); check("fmt data_hi", rd_v, dhi[k]);
            rd(`AUR_OFS_DATA);    check("fmt data", rd_v, dlo[k]);
        end
        // A size outside five to nine is refused; on and parity still take.
        wr(`AUR_OFS_CTRL, 8'hA1);
        rd(`AUR_OFS_CTRL); check("size kept", rd_v, 8'h71);
        $display("test formats done");
    endtask : t_formats

    task automatic print_verdict();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    initial
    begin
        // About five times the expected run.
        #200000;
        failures++;
        print_verdict();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_normal();
        t_noise();
        t_back();
        t_flush();
        t_formats();
        print_verdict();
    end
endmodule : tb_aur_rx

`default_nettype wire
